// ===== src/mcd_decoder.sv
/*
 * mcd_decoder: executes one motion command, answers status, code, value.
 * Assumes the host awaits each answer; motion and analog are same-clock.
 */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - code 1 turns motor right
// - code 2 turns motor left
// - code 54 stops motor named by X
// - code 4 moves motor, type picks mode
// - codes 5/6 write, read axis settings
// - codes 9/10 write, read module settings
// - codes 11/12 save, reload user variables
// - code 14 drives output, 15 samples input
// - code 19 acc op immediate
// - code 20 compares acc, keeps flags
// - code 27 waits for event or ticks
// - code 33 acc op X
// - codes 34/35 copy acc into settings
// - code 40 two user variables
// - codes 41/42 variable with acc
// - codes 43/44 variable with X
// - code 45 variable op immediate
// - codes 46/47 go to acc position
// - codes 50-53 turn at acc speed
// - code 48 restarts at address
// - code 49 decrements, branches if nonzero
// - codes 55-57 indexed variable access
// - code, type, bank bytes, four-byte value
module mcd_decoder
   import mcd_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // command from host
   input  wire logic               cmd_valid,
   output logic                    cmd_ready,
   input  wire logic [7:0]         cmd_code,
   input  wire logic [7:0]         cmd_type,
   input  wire logic [7:0]         cmd_bank,
   input  wire logic [31:0]        cmd_value,
   input  wire logic               prog_mode,
   // reply to host
   output logic                    rsp_valid,
   output logic [7:0]              rsp_status,
   output logic [7:0]              rsp_code,
   output logic [31:0]             rsp_value,
   // motion requests
   output logic                    mot_go,
   output logic [1:0]              mot_sel,
   output mcd_motion_t             mot_op,
   output logic [1:0]              mot_pos_type,
   output logic [31:0]             mot_value,
   input  wire logic [3:0]         mot_reached,
   // i/o ports
   output logic [7:0]              dig_out,
   input  wire logic [7:0]         dig_in,
   input  wire logic [7:0][15:0]   ana_in,
   // program state
   output logic [15:0]             prog_pc,
   output logic                    cmp_zero,
   output logic                    cmp_neg
);

   typedef enum {S_IDLE, S_WAIT} mcd_state_t;

   mcd_state_t  state_r;
   logic [31:0] acc_r, x_r, acc_nxt, x_nxt;
   logic [31:0] user_var [16];
   logic [31:0] nvm_var  [16];
   logic [31:0] mod_set  [16];
   logic [31:0] axis_set [4][16];
   logic [7:0]  din_s1, din_s2, din_s3, din_r;
   logic [7:0]  dout_nxt, status, wait_type_r;
   logic [15:0] pc_nxt;
   logic [1:0]  cmp_nxt, wait_mot_r;
   logic [31:0] rval, ticks_left_r, alu_a, alu_b, var_wd, mod_wd, axis_wd;
   logic [31:0] tick_cnt_r;
   logic [32:0] alu_out;
   logic        var_we, mod_we, axis_we, nvm_we, go, rd, wait_go, is_alu, tmo_en_r;
   logic        is_mot, use_x, use_acc, pos_chk;
   logic [3:0]  var_idx;
   mcd_dst_t    dst;
   mcd_motion_t mop;

   // argument fields and conditions, decoded straight from the command word, registers and mot_reached
   wire         take     = cmd_valid && (state_r == S_IDLE);
   wire         ok       = (status == ST_OK);
   wire         exec     = take && ok;
   wire [3:0]   bank_v   = cmd_bank[3:0];
   wire [3:0]   par_i    = cmd_type[3:0];
   wire [31:0]  var_bank = user_var[bank_v];
   wire [31:0]  var_val  = user_var[cmd_value[3:0]];
   wire [31:0]  var_x    = user_var[x_r[3:0]];
   wire         m_bad    = cmd_bank > MAX_MOTOR;
   wire         x_bad    = x_r > MAX_MOTOR_X;
   wire [31:0]  dec_var  = var_bank - 32'h0000_0001;
   wire         tick     = (tick_cnt_r == 32'(TICK_CYCLES - 1));
   wire         wait_hit = (wait_type_r == WAIT_REACH) && mot_reached[wait_mot_r];
   wire         wait_end = wait_hit || (tmo_en_r && ticks_left_r == 32'h0);

   assign cmd_ready = (state_r == S_IDLE);
   assign alu_out   = alu(par_i, alu_a, alu_b);

   // divide and modulo left out: a 32-bit divider costs more than the block
   function automatic logic [32:0] alu(input logic [3:0] op, input logic [31:0] a,
                                       input logic [31:0] b);
      logic [31:0] r;
      r = a * b;
      unique case (op)
         OP_ADD:  alu = {1'b0, a + b};
         OP_SUB:  alu = {1'b0, a - b};
         OP_MUL:  alu = {1'b0, r};
         OP_AND:  alu = {1'b0, a & b};
         OP_OR:   alu = {1'b0, a | b};
         OP_XOR:  alu = {1'b0, a ^ b};
         OP_NOT:  alu = {1'b0, ~a};
         OP_LOAD: alu = {1'b0, b};
         default: alu = {1'b1, a};
      endcase
   endfunction

   // command decode and execution plan
   always_comb begin
      status = ST_OK;          rval = 32'h0;     acc_nxt = acc_r;   x_nxt = x_r;
      var_we = 1'b0;           var_idx = bank_v; var_wd = 32'h0;
      mod_we = 1'b0;           mod_wd = cmd_value;
      axis_we = 1'b0;          axis_wd = cmd_value;
      nvm_we = 1'b0;           dout_nxt = dig_out;
      pc_nxt = prog_pc + 16'h0001;
      cmp_nxt = {cmp_zero, cmp_neg};
      rd = 1'b0;               wait_go = 1'b0;   go = 1'b0;
      is_mot = 1'b0;           use_x = 1'b0;     use_acc = 1'b0;   pos_chk = 1'b0;
      mop = MOT_STOP;          is_alu = 1'b0;    dst = DST_ACC;
      alu_a = acc_r;           alu_b = cmd_value;
      unique case (cmd_code)
         TURN_RIGHT_CMD:           begin is_mot = 1'b1; mop = MOT_RIGHT; end
         TURN_LEFT_CMD:            begin is_mot = 1'b1; mop = MOT_LEFT; end
         HALT_INDEXED_MOTOR_CMD:   begin is_mot = 1'b1; use_x = 1'b1; end
         GO_TO_POSITION_CMD:       begin is_mot = 1'b1; mop = MOT_GOTO; pos_chk = 1'b1; end
         GO_TO_ACC_POSITION_CMD: begin
            is_mot = 1'b1; mop = MOT_GOTO; pos_chk = 1'b1; use_acc = 1'b1;
         end
         GO_TO_ACC_POSITION_INDEXED_CMD: begin
            is_mot = 1'b1; mop = MOT_GOTO; pos_chk = 1'b1; use_acc = 1'b1; use_x = 1'b1;
         end
         TURN_LEFT_ACC_SPEED_CMD:  begin is_mot = 1'b1; mop = MOT_LEFT; use_acc = 1'b1; end
         TURN_RIGHT_ACC_SPEED_CMD: begin is_mot = 1'b1; mop = MOT_RIGHT; use_acc = 1'b1; end
         TURN_LEFT_INDEXED_CMD: begin
            is_mot = 1'b1; mop = MOT_LEFT; use_acc = 1'b1; use_x = 1'b1;
         end
         TURN_RIGHT_INDEXED_CMD: begin
            is_mot = 1'b1; mop = MOT_RIGHT; use_acc = 1'b1; use_x = 1'b1;
         end
         WRITE_AXIS_SETTING_CMD, ACC_TO_AXIS_SETTING_CMD: begin
            if (m_bad) status = ST_BAD_VALUE;
            else if (cmd_type > MAX_PARAM) status = ST_BAD_TYPE;
            axis_we = 1'b1;
            if (cmd_code == ACC_TO_AXIS_SETTING_CMD) axis_wd = acc_r;
         end
         READ_AXIS_SETTING_CMD: begin
            if (m_bad) status = ST_BAD_VALUE;
            else if (cmd_type > MAX_PARAM) status = ST_BAD_TYPE;
            rval = axis_set[cmd_bank[1:0]][par_i];
            rd = 1'b1;
         end
         WRITE_MODULE_SETTING_CMD, ACC_TO_MODULE_SETTING_CMD: begin
            if (cmd_type > MAX_PARAM) status = ST_BAD_TYPE;
            if (cmd_code == ACC_TO_MODULE_SETTING_CMD) mod_wd = acc_r;
            var_idx = par_i;
            var_wd = mod_wd;
            var_we = (cmd_bank == USER_BANK);
            mod_we = (cmd_bank != USER_BANK);
         end
         READ_MODULE_SETTING_CMD: begin
            if (cmd_type > MAX_PARAM) status = ST_BAD_TYPE;
            rval = (cmd_bank == USER_BANK) ? user_var[par_i] : mod_set[par_i];
            rd = 1'b1;
         end
         SAVE_USER_VAR_CMD, RELOAD_USER_VAR_CMD: begin
            if (cmd_bank != USER_BANK) status = ST_BAD_VALUE;
            else if (cmd_type > MAX_PARAM) status = ST_BAD_TYPE;
            var_idx = par_i;
            var_wd = nvm_var[par_i];
            nvm_we = (cmd_code == SAVE_USER_VAR_CMD);
            var_we = (cmd_code == RELOAD_USER_VAR_CMD);
         end
         DRIVE_OUTPUT_CMD: begin
            if (cmd_bank != DIG_BANK) status = ST_BAD_VALUE;
            else if (cmd_type > MAX_PORT) status = ST_BAD_TYPE;
            dout_nxt[cmd_type[2:0]] = cmd_value[0];
         end
         SAMPLE_INPUT_CMD: begin
            if (cmd_bank > ANA_BANK) status = ST_BAD_VALUE;
            else if (cmd_type > MAX_PORT) status = ST_BAD_TYPE;
            rval = (cmd_bank == ANA_BANK) ? {16'h0, ana_in[cmd_type[2:0]]}
                                          : {31'h0, din_r[cmd_type[2:0]]};
            rd = 1'b1;
         end
         ACC_IMMEDIATE_MATH_CMD: is_alu = 1'b1;
         COMPARE_CMD:
            cmp_nxt = {acc_r == cmd_value, $signed(acc_r) < $signed(cmd_value)};
         WAIT_EVENT_CMD: begin
            if (cmd_type > WAIT_REACH) status = ST_BAD_TYPE;
            else if (cmd_type == WAIT_REACH && m_bad) status = ST_BAD_VALUE;
            wait_go = 1'b1;
         end
         ACC_XREG_MATH_CMD: begin
            if (par_i == OP_LOAD) x_nxt = acc_r;
            else if (par_i == OP_SWAP) begin
               x_nxt = acc_r;
               acc_nxt = x_r;
            end else begin
               is_alu = 1'b1;
               alu_b = x_r;
            end
         end
         VAR_VAR_MATH_CMD:       begin is_alu = 1'b1; dst = DST_VAR; alu_a = var_bank; alu_b = var_val; end
         VAR_ACC_MATH_CMD:       begin is_alu = 1'b1; dst = DST_VAR; alu_a = var_bank; alu_b = acc_r; end
         ACC_VAR_MATH_CMD:       begin is_alu = 1'b1; alu_b = var_bank; end
         VAR_XREG_MATH_CMD:      begin is_alu = 1'b1; dst = DST_VAR; alu_a = var_bank; alu_b = x_r; end
         XREG_VAR_MATH_CMD:      begin is_alu = 1'b1; dst = DST_X; alu_a = x_r; alu_b = var_bank; end
         VAR_IMMEDIATE_MATH_CMD: begin is_alu = 1'b1; dst = DST_VAR; alu_a = var_bank; end
         RESTART_CMD: pc_nxt = cmd_value[15:0];
         COUNT_DOWN_BRANCH_CMD: begin
            var_we = 1'b1;
            var_wd = dec_var;
            if (dec_var != 32'h0) pc_nxt = cmd_value[15:0];
         end
         SET_INDEXED_VAR_CMD, ACC_TO_INDEXED_VAR_CMD: begin
            if (x_r > MAX_VAR_X) status = ST_BAD_VALUE;
            var_we = 1'b1;
            var_idx = x_r[3:0];
            var_wd = (cmd_code == ACC_TO_INDEXED_VAR_CMD) ? acc_r : cmd_value;
         end
         GET_INDEXED_VAR_CMD: begin
            if (x_r > MAX_VAR_X) status = ST_BAD_VALUE;
            rval = var_x;
            rd = 1'b1;
         end
         default: status = ST_BAD_CMD;
      endcase
      // shared tail for motion requests
      if (is_mot) begin
         if (use_x ? x_bad : m_bad) status = ST_BAD_VALUE;
         else if (pos_chk && cmd_type > MAX_POS) status = ST_BAD_TYPE;
         go = 1'b1;
      end
      // shared tail for arithmetic; unsupported operations write nothing
      if (is_alu) begin
         if (alu_out[32]) status = ST_BAD_TYPE;
         unique case (dst)
            DST_ACC: acc_nxt = alu_out[31:0];
            DST_X:   x_nxt = alu_out[31:0];
            DST_VAR: begin var_we = 1'b1; var_wd = alu_out[31:0]; end
         endcase
      end
      // reads only touch the accumulator while a program runs
      if (rd && prog_mode) acc_nxt = rval;
   end

   // input pins: three stages, a bit sets once stages two and three agree high and clears whenever they differ
   always_ff @(posedge clk) begin
      din_s1 <= dig_in;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
      din_r  <= rst ? 8'h00 : (din_r & ~(din_s2 ^ din_s3)) | (din_s3 & ~(din_s2 ^ din_s3));
   end

   // storage arrays; every write is gated by a good status
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            user_var[i] <= 32'h0;
            nvm_var[i]  <= 32'h0;
            mod_set[i]  <= 32'h0;
            for (int m = 0; m < 4; m++) axis_set[m][i] <= 32'h0;
         end
      end else if (exec) begin
         if (var_we) user_var[var_idx] <= var_wd;
         if (nvm_we) nvm_var[par_i] <= user_var[par_i];
         if (mod_we) mod_set[par_i] <= mod_wd;
         if (axis_we) axis_set[cmd_bank[1:0]][par_i] <= axis_wd;
      end
   end

   // registers, motion strobe and reply
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_r <= 32'h0;        x_r <= 32'h0;          prog_pc <= 16'h0;
         cmp_zero <= 1'b0;      cmp_neg <= 1'b0;       dig_out <= 8'h00;
         mot_go <= 1'b0;        mot_sel <= 2'h0;       mot_op <= MOT_STOP;
         mot_pos_type <= 2'h0;  mot_value <= 32'h0;
         rsp_valid <= 1'b0;     rsp_status <= 8'h00;   rsp_code <= 8'h00;
         rsp_value <= 32'h0;
      end else begin
         mot_go <= exec && go;
         rsp_valid <= (take && !(ok && wait_go)) || (state_r == S_WAIT && wait_end);
         if (take) begin
            rsp_status <= status;
            rsp_code <= cmd_code;
            rsp_value <= ok ? rval : 32'h0;
         end else if (state_r == S_WAIT) begin
            rsp_status <= ST_OK;
            rsp_value <= 32'h0;
         end
         if (exec) begin
            acc_r <= acc_nxt;
            x_r <= x_nxt;
            prog_pc <= pc_nxt;
            {cmp_zero, cmp_neg} <= cmp_nxt;
            dig_out <= dout_nxt;
            mot_sel <= use_x ? x_r[1:0] : cmd_bank[1:0];
            mot_op <= mop;
            mot_pos_type <= cmd_type[1:0];
            mot_value <= use_acc ? acc_r : cmd_value;
         end
      end
   end

   // wait sequencer: tick prescaler and remaining tick count
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= S_IDLE;
         wait_type_r <= 8'h00;  wait_mot_r <= 2'h0;    tmo_en_r <= 1'b0;
         ticks_left_r <= 32'h0; tick_cnt_r <= 32'h0;
      end else if (state_r == S_IDLE) begin
         tick_cnt_r <= 32'h0;
         if (exec && wait_go) begin
            state_r <= S_WAIT;
            wait_type_r <= cmd_type;
            wait_mot_r <= cmd_bank[1:0];
            tmo_en_r <= (cmd_type == WAIT_TICKS) || (cmd_value != 32'h0);
            ticks_left_r <= cmd_value;
         end
      end else begin
         tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
         if (tick && ticks_left_r != 32'h0) ticks_left_r <= ticks_left_r - 32'h1;
         if (wait_end) state_r <= S_IDLE;
      end
   end

endmodule // mcd_decoder
`default_nettype wire

// ===== common/mcd_pkg.sv
/*
 * mcd_pkg: codes, limits and types of the command decoder.
 * Assumes one clock and one command in flight.
 */
`default_nettype none
package mcd_pkg;
   // clock and wait tick timing
   localparam int CLK_PERIOD_NS   = 4;
   localparam int TICK_MS         = 10;
   localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_PERIOD_NS;

   // command codes
   localparam logic [7:0] TURN_RIGHT_CMD                 = 8'h01;
   localparam logic [7:0] TURN_LEFT_CMD                  = 8'h02;
   localparam logic [7:0] GO_TO_POSITION_CMD             = 8'h04;
   localparam logic [7:0] WRITE_AXIS_SETTING_CMD         = 8'h05;
   localparam logic [7:0] READ_AXIS_SETTING_CMD          = 8'h06;
   localparam logic [7:0] WRITE_MODULE_SETTING_CMD       = 8'h09;
   localparam logic [7:0] READ_MODULE_SETTING_CMD        = 8'h0a;
   localparam logic [7:0] SAVE_USER_VAR_CMD              = 8'h0b;
   localparam logic [7:0] RELOAD_USER_VAR_CMD            = 8'h0c;
   localparam logic [7:0] DRIVE_OUTPUT_CMD               = 8'h0e;
   localparam logic [7:0] SAMPLE_INPUT_CMD               = 8'h0f;
   localparam logic [7:0] ACC_IMMEDIATE_MATH_CMD         = 8'h13;
   localparam logic [7:0] COMPARE_CMD                    = 8'h14;
   localparam logic [7:0] WAIT_EVENT_CMD                 = 8'h1b;
   localparam logic [7:0] ACC_XREG_MATH_CMD              = 8'h21;
   localparam logic [7:0] ACC_TO_AXIS_SETTING_CMD        = 8'h22;
   localparam logic [7:0] ACC_TO_MODULE_SETTING_CMD      = 8'h23;
   localparam logic [7:0] VAR_VAR_MATH_CMD               = 8'h28;
   localparam logic [7:0] VAR_ACC_MATH_CMD               = 8'h29;
   localparam logic [7:0] ACC_VAR_MATH_CMD               = 8'h2a;
   localparam logic [7:0] VAR_XREG_MATH_CMD              = 8'h2b;
   localparam logic [7:0] XREG_VAR_MATH_CMD              = 8'h2c;
   localparam logic [7:0] VAR_IMMEDIATE_MATH_CMD         = 8'h2d;
   localparam logic [7:0] GO_TO_ACC_POSITION_CMD         = 8'h2e;
   localparam logic [7:0] GO_TO_ACC_POSITION_INDEXED_CMD = 8'h2f;
   localparam logic [7:0] RESTART_CMD                    = 8'h30;
   localparam logic [7:0] COUNT_DOWN_BRANCH_CMD          = 8'h31;
   localparam logic [7:0] TURN_LEFT_ACC_SPEED_CMD        = 8'h32;
   localparam logic [7:0] TURN_RIGHT_ACC_SPEED_CMD       = 8'h33;
   localparam logic [7:0] TURN_LEFT_INDEXED_CMD          = 8'h34;
   localparam logic [7:0] TURN_RIGHT_INDEXED_CMD         = 8'h35;
   localparam logic [7:0] HALT_INDEXED_MOTOR_CMD         = 8'h36;
   localparam logic [7:0] SET_INDEXED_VAR_CMD            = 8'h37;
   localparam logic [7:0] GET_INDEXED_VAR_CMD            = 8'h38;
   localparam logic [7:0] ACC_TO_INDEXED_VAR_CMD         = 8'h39;

   // reply status codes
   localparam logic [7:0] ST_OK        = 8'h64;
   localparam logic [7:0] ST_BAD_CMD   = 8'h02;
   localparam logic [7:0] ST_BAD_TYPE  = 8'h03;
   localparam logic [7:0] ST_BAD_VALUE = 8'h04;

   // field limits and selectors
   localparam logic [7:0]  MAX_MOTOR   = 8'h03;
   localparam logic [31:0] MAX_MOTOR_X = 32'h0000_0003;
   localparam logic [31:0] MAX_VAR_X   = 32'h0000_000f;
   localparam logic [7:0]  MAX_PARAM   = 8'h0f;
   localparam logic [7:0]  MAX_PORT    = 8'h07;
   localparam logic [7:0]  MAX_POS     = 8'h02;
   localparam logic [7:0]  USER_BANK   = 8'h02;
   localparam logic [7:0]  DIG_BANK    = 8'h00;
   localparam logic [7:0]  ANA_BANK    = 8'h01;
   localparam logic [7:0]  WAIT_TICKS  = 8'h00;
   localparam logic [7:0]  WAIT_REACH  = 8'h01;

   // arithmetic operations carried in the type field
   localparam logic [3:0] OP_ADD  = 4'h0;
   localparam logic [3:0] OP_SUB  = 4'h1;
   localparam logic [3:0] OP_MUL  = 4'h2;
   localparam logic [3:0] OP_AND  = 4'h5;
   localparam logic [3:0] OP_OR   = 4'h6;
   localparam logic [3:0] OP_XOR  = 4'h7;
   localparam logic [3:0] OP_NOT  = 4'h8;
   localparam logic [3:0] OP_LOAD = 4'h9;
   localparam logic [3:0] OP_SWAP = 4'ha;

   typedef enum logic [1:0] {MOT_RIGHT, MOT_LEFT, MOT_STOP, MOT_GOTO} mcd_motion_t;
   typedef enum logic [1:0] {DST_ACC, DST_X, DST_VAR} mcd_dst_t;
endpackage
`default_nettype wire

// ===== verification/mcd_props.sv
/*
 * mcd_props: checks on the decoder's ports.
 * Assumes it is bound to mcd_decoder.
 */
`timescale 1ns/100ps
`default_nettype none
module mcd_props
   import mcd_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // command and reply
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic [7:0]  cmd_code,
   input wire logic [7:0]  cmd_type,
   input wire logic [7:0]  cmd_bank,
   input wire logic [31:0] cmd_value,
   input wire logic        rsp_valid,
   input wire logic [7:0]  rsp_status,
   input wire logic [7:0]  rsp_code,
   // motion and program state
   input wire logic        mot_go,
   input wire logic [1:0]  mot_sel,
   input wire mcd_motion_t mot_op,
   input wire logic [1:0]  mot_pos_type,
   input wire logic [31:0] mot_value,
   input wire logic [15:0] prog_pc
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // a command is taken where valid meets ready
   wire tk = cmd_valid && cmd_ready;
   wire mot_ok = cmd_bank <= MAX_MOTOR;

   reply_next_a: assert property (tk && cmd_code != WAIT_EVENT_CMD |=> rsp_valid &&
      rsp_code == $past(cmd_code)) else $error("reply late or code not echoed");
   right_turn_a: assert property (tk && cmd_code == TURN_RIGHT_CMD && mot_ok |=> mot_go &&
      mot_op == MOT_RIGHT && mot_sel == $past(cmd_bank[1:0]) && mot_value == $past(cmd_value))
      else $error("right turn request wrong");
   left_turn_a: assert property (tk && cmd_code == TURN_LEFT_CMD && mot_ok |=> mot_go &&
      mot_op == MOT_LEFT && mot_value == $past(cmd_value)) else $error("left turn wrong");
   goto_mode_a: assert property (tk && cmd_code == GO_TO_POSITION_CMD && mot_ok &&
      cmd_type <= MAX_POS |=> mot_go && mot_op == MOT_GOTO &&
      mot_pos_type == $past(cmd_type[1:0])) else $error("position move wrong");
   bad_code_a: assert property (tk && cmd_code == 8'h03 |=> rsp_status == ST_BAD_CMD &&
      !mot_go && prog_pc == $past(prog_pc)) else $error("undefined code not refused");
   wait_busy_a: assert property (tk && cmd_code == WAIT_EVENT_CMD && cmd_type <= WAIT_REACH &&
      mot_ok |=>
      !cmd_ready && !rsp_valid) else $error("wait did not hold off host");
   wait_zero_a: assert property (tk && cmd_code == WAIT_EVENT_CMD && cmd_type == WAIT_TICKS &&
      cmd_value == 32'h0 |=> ##1 rsp_valid) else $error("zero wait reply late");
   restart_pc_a: assert property (tk && cmd_code == RESTART_CMD |=>
      prog_pc == $past(cmd_value[15:0])) else $error("restart address wrong");
endmodule // mcd_props
`default_nettype wire

// ===== verification/mcd_motion_model.sv
/*
 * mcd_motion_model: flags a target reached a few cycles after a position move.
 * Assumes the decoder's clock.
 */
`timescale 1ns/100ps
`default_nettype none
module mcd_motion_model
   import mcd_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // requests and status
   input  wire logic       mot_go,
   input  wire logic [1:0] mot_sel,
   input  wire mcd_motion_t mot_op,
   output logic [3:0]      mot_reached
);
   logic [2:0] cnt_r;
   logic [1:0] sel_r;
   // any new request clears the motor's flag, a position move sets it five cycles on
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 3'h0;
         mot_reached <= 4'h0;
      end else if (mot_go) begin
         mot_reached[mot_sel] <= 1'b0;
         sel_r <= mot_sel;
         cnt_r <= (mot_op == MOT_GOTO) ? 3'h5 : 3'h0;
      end else if (cnt_r != 3'h0) begin
         cnt_r <= cnt_r - 3'h1;
         if (cnt_r == 3'h1) mot_reached[sel_r] <= 1'b1;
      end
   end
endmodule // mcd_motion_model
`default_nettype wire

// ===== verification/tb_top.sv
/*
 * tb_top: directed bench for the decoder and motion model.
 * Assumes a short tick count.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import mcd_pkg::*;
   logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, prog_mode = 1'b1;
   logic [7:0] cmd_code = 8'h0, cmd_type = 8'h0, cmd_bank = 8'h0, dig_in = 8'h08;
   logic [31:0] cmd_value = 32'h0;
   logic [7:0][15:0] ana_in = {8{16'h0a5c}}; // same sample on every channel
   logic cmd_ready, rsp_valid, mot_go, cmp_zero, cmp_neg, mg;
   logic [7:0] rsp_status, rsp_code, dig_out, rs;
   logic [31:0] rsp_value, mot_value, rv;
   logic [1:0] mot_sel, mot_pos_type;
   mcd_motion_t mot_op;
   logic [3:0] mot_reached;
   logic [15:0] prog_pc, pc0;
   int bad_count = 0, n_compared = 0, cyc = 0, lat;

   mcd_decoder #(.TICK_CYCLES(4)) u_dut (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_code,
      .cmd_type, .cmd_bank, .cmd_value, .prog_mode, .rsp_valid, .rsp_status, .rsp_code,
      .rsp_value, .mot_go, .mot_sel, .mot_op, .mot_pos_type, .mot_value, .mot_reached,
      .dig_out, .dig_in, .ana_in, .prog_pc, .cmp_zero, .cmp_neg);
   mcd_motion_model u_mot (.clk, .rst, .mot_go, .mot_sel, .mot_op, .mot_reached);

   initial forever #2 clk = ~clk;
   // hang guard: a stuck handshake ends the run as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one command, held until taken; reply read at the falling edge
   task automatic send(logic [7:0] c, logic [7:0] t = 8'h00, logic [7:0] b = 8'h00,
                       logic [31:0] v = 32'h0, logic [7:0] es = ST_OK);
      @(posedge clk);
      {cmd_valid, cmd_code, cmd_type, cmd_bank, cmd_value} <= {1'b1, c, t, b, v};
      do @(posedge clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
      end while (rsp_valid !== 1'b1 && lat < 200);
      {rs, rv, mg} = {rsp_status, rsp_value, mot_go};
      chk("status", 32'(es), 32'(rs));
   endtask
   task automatic lda(logic [31:0] v);
      send(ACC_IMMEDIATE_MATH_CMD, 8'h09, 8'h00, v);
   endtask
   task automatic setx(logic [31:0] v);
      lda(v);
      send(ACC_XREG_MATH_CMD, 8'h09);
   endtask
   task automatic mchk(mcd_motion_t op, logic [1:0] s, logic [31:0] v);
      chk("motion", {27'h0, 1'b1, op, s}, {27'h0, mg, mot_op, mot_sel});
      chk("speed", v, mot_value);
   endtask

   task automatic t_motion;
      send(TURN_RIGHT_CMD, 8'h00, 8'h01, 32'h100); mchk(MOT_RIGHT, 2'h1, 32'h100);
      send(TURN_LEFT_CMD, 8'h00, 8'h02, 32'h55); mchk(MOT_LEFT, 2'h2, 32'h55);
      send(GO_TO_POSITION_CMD, 8'h01, 8'h03, 32'h40); mchk(MOT_GOTO, 2'h3, 32'h40);
      chk("pos type", 32'h1, {30'h0, mot_pos_type});
      setx(32'h2);
      send(HALT_INDEXED_MOTOR_CMD); chk("stop", 32'ha, {28'h0, mot_op, mot_sel});
      send(TURN_LEFT_INDEXED_CMD); mchk(MOT_LEFT, 2'h2, 32'h2);
      send(GO_TO_ACC_POSITION_CMD, 8'h00, 8'h01); mchk(MOT_GOTO, 2'h1, 32'h2);
   endtask
   task automatic t_math;
      lda(32'ha);
      send(ACC_IMMEDIATE_MATH_CMD, 8'h00, 8'h00, 32'h5);
      send(ACC_IMMEDIATE_MATH_CMD, 8'h02, 8'h00, 32'h3);
      send(GO_TO_ACC_POSITION_CMD); mchk(MOT_GOTO, 2'h0, 32'h2d);
      send(COMPARE_CMD, 8'h00, 8'h00, 32'h2d); chk("cmp eq", 32'h2, {cmp_zero, cmp_neg});
      send(COMPARE_CMD, 8'h00, 8'h00, 32'h2e); chk("cmp lt", 32'h1, {cmp_zero, cmp_neg});
      setx(32'h7);
      lda(32'h3);
      send(ACC_XREG_MATH_CMD, 8'h01);
      send(GO_TO_ACC_POSITION_CMD); mchk(MOT_GOTO, 2'h0, 32'hfffffffc);
   endtask
   task automatic t_params;
      send(WRITE_AXIS_SETTING_CMD, 8'h03, 8'h01, 32'h77);
      send(READ_AXIS_SETTING_CMD, 8'h03, 8'h01); chk("axis", 32'h77, rv);
      send(WRITE_MODULE_SETTING_CMD, 8'h04, 8'h00, 32'h99);
      send(READ_MODULE_SETTING_CMD, 8'h04); chk("module", 32'h99, rv);
      send(WRITE_MODULE_SETTING_CMD, 8'h01, USER_BANK, 32'h11);
      send(SAVE_USER_VAR_CMD, 8'h01, USER_BANK);
      send(WRITE_MODULE_SETTING_CMD, 8'h01, USER_BANK, 32'h22);
      send(RELOAD_USER_VAR_CMD, 8'h01, USER_BANK);
      send(READ_MODULE_SETTING_CMD, 8'h01, USER_BANK); chk("reload", 32'h11, rv);
      lda(32'h33);
      send(ACC_TO_AXIS_SETTING_CMD, 8'h03, 8'h01);
      send(READ_AXIS_SETTING_CMD, 8'h03, 8'h01); chk("acc copy", 32'h33, rv);
   endtask
   task automatic t_io_wait;
      send(DRIVE_OUTPUT_CMD, 8'h02, DIG_BANK, 32'h1); chk("dig out", 32'h4, {24'h0, dig_out});
      send(SAMPLE_INPUT_CMD, 8'h03, DIG_BANK); chk("dig in", 32'h1, rv);
      send(SAMPLE_INPUT_CMD, 8'h05, ANA_BANK); chk("ana in", 32'h0a5c, rv);
      send(WAIT_EVENT_CMD, WAIT_TICKS); chk("zero wait", 32'h1, 32'(lat == 2));
      send(WAIT_EVENT_CMD, WAIT_TICKS, 8'h00, 32'h2); chk("tick wait", 32'h1, 32'(lat > 8));
      send(GO_TO_POSITION_CMD, 8'h00, 8'h02, 32'h10);
      send(WAIT_EVENT_CMD, WAIT_REACH, 8'h02); chk("reach wait", 32'h1, 32'(lat < 12));
   endtask
   task automatic t_flow;
      send(RESTART_CMD, 8'h00, 8'h00, 32'h20); chk("pc", 32'h20, {16'h0, prog_pc});
      send(WRITE_MODULE_SETTING_CMD, 8'h00, USER_BANK, 32'h2);
      send(COUNT_DOWN_BRANCH_CMD, 8'h00, 8'h00, 32'h40); chk("branch", 32'h40, prog_pc);
      send(COUNT_DOWN_BRANCH_CMD, 8'h00, 8'h00, 32'h40); chk("fall", 32'h41, prog_pc);
      setx(32'h3);
      send(SET_INDEXED_VAR_CMD, 8'h00, 8'h00, 32'h5a);
      send(GET_INDEXED_VAR_CMD); chk("idx set", 32'h5a, rv);
      lda(32'h6b);
      send(ACC_TO_INDEXED_VAR_CMD);
      send(GET_INDEXED_VAR_CMD); chk("idx acc", 32'h6b, rv);
   endtask
   task automatic t_bad;
      pc0 = prog_pc;
      send(8'h03, 8'h00, 8'h00, 32'h0, ST_BAD_CMD);
      chk("bad", {7'h0, ST_BAD_CMD, 1'b0, pc0}, {7'h0, rs, mg, prog_pc});
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_motion();
      t_math();
      t_params();
      t_io_wait();
      t_flow();
      t_bad();
      summarize();
   end
endmodule // tb_top
bind mcd_decoder mcd_props u_props (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_code, .cmd_type,
   .cmd_bank, .cmd_value, .rsp_valid, .rsp_status, .rsp_code, .mot_go, .mot_sel, .mot_op,
   .mot_pos_type, .mot_value, .prog_pc);
`default_nettype wire
